// >>> dv/stim_host_model.sv
// Host-side model: drives the sleep/trigger pin and counts interrupts.
// Assumes the bench sets wantHigh by non-blocking assignment after an edge.
`timescale 1ns/1ps
module stim_host_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wantHigh,
    input wire logic irqPin,
    output logic sleepTriggerPin,
    output logic [7:0] irqCount
);
    logic irqLast_r;
    // falling edge wakes
    // Pin follows the request one edge late, like a GPIO port register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sleepTriggerPin <= 1'b0;
        end else begin
            sleepTriggerPin <= wantHigh;
        end
    end
    // interrupt edge seen
    // Counting rising edges tells the bench a status read is owed
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irqLast_r <= 1'b0;
            irqCount <= 8'h00;
        end else begin
            irqLast_r <= irqPin;
            if (irqPin && !irqLast_r) begin
                irqCount <= irqCount + 8'h01;
            end
        end
    end
endmodule : stim_host_model

// >>> dv/tb_top.sv
// Bench for the sleep/trigger and interrupt block.
// Assumes one AHB-Lite slave (hready is its hreadyout) and the host model on the pin.
`timescale 1ns/1ps
`include "stim_cfg.svh"
module tb_top;
    import stim_pkg::*;
    localparam logic [31:0] A_CLK = 32'(`STIM_IDX_CLKCTRL) * 4;
    localparam logic [31:0] A_MASK = 32'(`STIM_IDX_MASK) * 4;
    localparam logic [31:0] A_FLAGS = 32'(`STIM_IDX_FLAGS) * 4;
    localparam int BIT_OF [6] = '{`STIM_B_LOCK, `STIM_B_UNLOCK, `STIM_B_SFD, `STIM_B_DONE, `STIM_B_UNDERRUN,
        `STIM_B_SUPPLY};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irqPin, clockOutPin, paEnable, sleepTriggerPin;
    logic wantHigh = 1'b0;
    logic ran;
    logic [7:0] irqCount;
    logic [31:0] rd;
    stim_evt_t evtIn = '0;
    stim_cmd_t cmdIn = '0;
    stim_state_t trxState;
    stim_state_t rdyS [2] = '{SYNTH_READY, TX_AUTORETRY_READY};
    stim_state_t txS [2] = '{TX_BUSY, TRANSMITTING_AUTORETRY};
    stim_state_t lsS [2] = '{LISTEN, LISTEN_AUTOACK};
    stim_state_t ncS [2] = '{LISTEN_CLOCKLESS, LISTEN_AUTOACK_CLOCKLESS};
    stim_state_t rxS [2] = '{RECEIVING, RECEIVING_AUTOACK};
    int bad_count = 0;
    int compares = 0;

    // Free-running 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    stim_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sleepTriggerPin(sleepTriggerPin), .evtIn(evtIn),
        .cmdIn(cmdIn), .irqPin(irqPin), .clockOutPin(clockOutPin), .paEnable(paEnable), .trxState(trxState));

    stim_host_model u_host (.ref_clk(ref_clk), .resetn(resetn), .wantHigh(wantHigh), .irqPin(irqPin),
        .sleepTriggerPin(sleepTriggerPin), .irqCount(irqCount));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    // One single word transfer; address held until ready, data until ready again
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wdata;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask : bus

    task automatic pulse(input stim_evt_t e);
        evtIn <= e;
        @(posedge ref_clk);
        evtIn <= '0;
        @(posedge ref_clk);
    endtask : pulse

    task automatic cmd(input stim_state_t t);
        cmdIn <= '{1'b1, t};
        @(posedge ref_clk);
        cmdIn <= '0;
        idle(2);
    endtask : cmd

    // Pin edges take about five edges to act; eight leaves margin
    task automatic pin(input logic v);
        wantHigh <= v;
        idle(8);
    endtask : pin

    task automatic clk_runs(output logic r);
        logic first;
        first = clockOutPin;
        r = 1'b0;
        repeat (4) begin
            @(posedge ref_clk);
            if (clockOutPin !== first) r = 1'b1;
        end
    endtask : clk_runs

    // Hang guard, well past the few hundred cycles the tests need
    initial begin
        #400us;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        idle(10);
        resetn <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, A_MASK, 32'h0, rd);
        check(rd, 32'h000000ff, "mask reset");
        bus(1'b0, A_FLAGS, 32'h0, rd);
        check(rd, 32'h0, "flags reset");
        $display("test reset finished");
        for (int i = 0; i < 6; i++) begin
            pulse(stim_evt_t'(6'h01 << i));
            check(32'(irqPin), 32'h1, "irq set");
            bus(1'b0, A_FLAGS, 32'h0, rd);
            check(rd, 32'h1 << BIT_OF[i], "flag bit");
            idle(1);
            check(32'(irqPin), 32'h0, "irq cleared");
            check(32'(irqCount), i + 1, "irq edge count");
        end
        $display("test events finished");
        bus(1'b1, A_MASK, 32'h000000f7, rd);
        bus(1'b0, A_MASK, 32'h0, rd);
        check(rd, 32'h000000f7, "mask readback");
        pulse('{frameDone: 1'b1, default: 1'b0});
        check(32'(irqPin), 32'h0, "masked event");
        pulse('{bufferUnderrun: 1'b1, default: 1'b0});
        check(32'(irqPin), 32'h1, "enabled event");
        bus(1'b0, A_FLAGS, 32'h0, rd);
        bus(1'b1, A_MASK, 32'h000000ff, rd);
        bus(1'b1, A_FLAGS, 32'h000000ff, rd);
        bus(1'b0, A_FLAGS, 32'h0, rd);
        check(rd, 32'h0, "flags read-only");
        check(32'(hresp), 32'h0, "okay response");
        pulse('{supplyLow: 1'b1, default: 1'b0});
        pulse('{lockGained: 1'b1, default: 1'b0});
        pulse('{lockLost: 1'b1, default: 1'b0});
        bus(1'b0, A_FLAGS, 32'h0, rd);
        check(rd, 32'h00000082, "lock pair");
        fork
            bus(1'b0, A_FLAGS, 32'h0, rd);
            pulse('{bufferUnderrun: 1'b1, default: 1'b0});
        join
        bus(1'b0, A_FLAGS, 32'h0, rd);
        check(rd, 32'h00000040, "event during read");
        $display("test mask and flags finished");
        pin(1'b1);
        check(32'(trxState), 32'(SLEEP_WAIT), "sleep wait");
        clk_runs(ran);
        check(32'(ran), 32'h1, "clock before stop");
        idle(30);
        clk_runs(ran);
        check(32'(trxState), 32'(SLEEP), "sleep");
        check(32'(ran), 32'h0, "clock stopped");
        pin(1'b0);
        check(32'(trxState), 32'(IDLE_CLOCK), "wake");
        clk_runs(ran);
        check(32'(ran), 32'h1, "clock back");
        bus(1'b1, A_CLK, 32'h0, rd);
        pin(1'b1);
        check(32'(trxState), 32'(SLEEP), "sleep at once");
        pin(1'b0);
        bus(1'b1, A_CLK, 32'h1, rd);
        $display("test sleep finished");
        for (int k = 0; k < 2; k++) begin
            cmd(rdyS[k]);
            pin(1'b1);
            check(32'(trxState), 32'(txS[k]), "tx start");
            check(32'(paEnable), 32'h1, "amp on");
            pulse('{lockLost: 1'b1, default: 1'b0});
            check(32'(paEnable), 32'h0, "amp off on unlock");
            pin(1'b0);
            check(32'(trxState), 32'(txS[k]), "fall ignored");
            pulse('{frameDone: 1'b1, default: 1'b0});
            check(32'(trxState), 32'(rdyS[k]), "tx done");
            bus(1'b0, A_FLAGS, 32'h0, rd);
            check(rd, 32'h0000000a, "tx flags");
            cmd(IDLE_CLOCK);
        end
        $display("test transmit finished");
        for (int k = 0; k < 2; k++) begin
            cmd(lsS[k]);
            pin(1'b1);
            check(32'(trxState), 32'(ncS[k]), "clockless");
            idle(36);
            clk_runs(ran);
            check(32'(ran), 32'h0, "clock stopped");
            pulse('{sfdDetect: 1'b1, default: 1'b0});
            check(32'(trxState), 32'(rxS[k]), "receiving");
            clk_runs(ran);
            check(32'(ran), 32'h1, "clock restarted");
            pulse('{frameDone: 1'b1, default: 1'b0});
            idle(10);
            check(32'(trxState), 32'(lsS[k]), "back to listen");
            pin(1'b0);
            bus(1'b0, A_FLAGS, 32'h0, rd);
            check(rd, 32'h0000000c, "rx flags");
            cmd(IDLE_CLOCK);
        end
        cmd(LISTEN);
        pin(1'b1);
        pin(1'b0);
        check(32'(trxState), 32'(LISTEN), "fall leaves clockless");
        clk_runs(ran);
        check(32'(ran), 32'h1, "clock kept");
        cmd(IDLE_CLOCK);
        $display("test listen finished");
        tally_and_finish();
    end
endmodule : tb_top

// >>> verilog/stim_cfg.svh
// Constants for the sleep/trigger and interrupt block.
// Assumes a 50 MHz ref_clk and 32-bit AHB-Lite register access.
`ifndef STIM_CFG_SVH
`define STIM_CFG_SVH
// Register indices; byte address is four times the index
`define STIM_IDX_STATE 8'h01
`define STIM_IDX_CLKCTRL 8'h03
`define STIM_IDX_MASK 8'h0e
`define STIM_IDX_FLAGS 8'h0f
// Reset values
`define STIM_MASK_RST 8'hff
`define STIM_FLAGS_RST 8'h00
`define STIM_CLKCTRL_RST 3'h1
// Flag bit positions
`define STIM_B_LOCK 0
`define STIM_B_UNLOCK 1
`define STIM_B_SFD 2
`define STIM_B_DONE 3
`define STIM_B_UNDERRUN 6
`define STIM_B_SUPPLY 7
// Clock-out stop delay, 35 clock cycles
`define STIM_STOP_CYC 6'h23
`endif

// >>> verilog/stim_clkout.sv
// Clock output generator with delayed stop.
// Assumes stopReq and startReq are one-cycle pulses from the main FSM.
`timescale 1ns/1ps
`include "stim_cfg.svh"
module stim_clkout (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ctrlOn,
    input wire logic stopReq,
    input wire logic startReq,
    output logic clockOut,
    output logic stopDone
);
    logic run_r;
    logic [5:0] cnt_r;
    // Start beats a pending stop so a quick falling edge keeps the clock
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            run_r <= 1'b1;
            cnt_r <= 6'h00;
            stopDone <= 1'b0;
        end else begin
            stopDone <= 1'b0;
            if (startReq) begin
                run_r <= 1'b1;
                cnt_r <= 6'h00;
            end else if (stopReq) begin
                cnt_r <= `STIM_STOP_CYC;
            end else if (cnt_r != 6'h00) begin
                cnt_r <= cnt_r - 6'h01;
                if (cnt_r == 6'h01) begin
                    run_r <= 1'b0;
                    stopDone <= 1'b1;
                end
            end
        end
    end
    // Divide by two; parks low when stopped or disabled
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clockOut <= 1'b0;
        end else begin
            clockOut <= run_r & ctrlOn & ~clockOut;
        end
    end
endmodule : stim_clkout

// >>> verilog/stim_pkg.sv
// Types for the sleep/trigger and interrupt block.
// Assumes stim_cfg.svh is compiled with it.
package stim_pkg;
    // Radio states seen by this block
    typedef enum logic [3:0] {
        IDLE_CLOCK, SLEEP_WAIT, SLEEP, SYNTH_READY, TX_AUTORETRY_READY,
        TX_BUSY, TRANSMITTING_AUTORETRY, LISTEN, LISTEN_AUTOACK,
        LISTEN_CLOCKLESS, LISTEN_AUTOACK_CLOCKLESS, RECEIVING,
        RECEIVING_AUTOACK
    } stim_state_t;
    // One-cycle events from the radio core
    typedef struct packed {
        logic supplyLow;
        logic bufferUnderrun;
        logic frameDone;
        logic sfdDetect;
        logic lockLost;
        logic lockGained;
    } stim_evt_t;
    // Host state command from the register access path
    typedef struct packed {
        logic valid;
        stim_state_t target;
    } stim_cmd_t;
endpackage : stim_pkg

// >>> verilog/stim_sync.sv
// Two-flop synchroniser with edge detection for the sleep/trigger pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
module stim_sync (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic pinIn,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;
    // Only sync_r looks at the first stage
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pinIn;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end
    // Edges are registered so they come straight from flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= sync_r & ~last_r;
            fall <= ~sync_r & last_r;
        end
    end
endmodule : stim_sync

// >>> verilog/stim_top.sv
// Sleep/trigger pin state logic, clock output gating and interrupt flags.
// Assumes AHB-Lite slave on ref_clk; events and commands come from
// logic on the same clock; the trigger pin is asynchronous.
`timescale 1ns/1ps
`include "stim_cfg.svh"
module stim_top (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sleepTriggerPin,
    input wire stim_pkg::stim_evt_t evtIn,
    input wire stim_pkg::stim_cmd_t cmdIn,
    output logic irqPin,
    output logic clockOutPin,
    output logic paEnable,
    output stim_pkg::stim_state_t trxState
);
    import stim_pkg::*;

    logic pinRise;
    logic pinFall;
    logic stopReq;
    logic startReq;
    logic stopDone;
    logic ctrlOn;
    logic wrPend_r;
    logic [7:0] wrIdx_r;
    logic [7:0] mask_r;
    logic [7:0] flags_r;
    logic [7:0] flagsNxt;
    logic [7:0] evtSet;
    logic [7:0] evtClr;
    logic [2:0] clkCtrl_r;
    logic rdStatus;
    logic addrPhase;
    stim_state_t state_r;
    stim_state_t stateNxt;

    // Register index hit; used by read and clear decode
    function automatic logic hitIdx(input logic [31:0] a, input logic [7:0] idx);
        hitIdx = (a[9:2] == idx) && (a[31:10] == 22'h000000);
    endfunction : hitIdx

    stim_sync u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pinIn(sleepTriggerPin),
        .rise(pinRise),
        .fall(pinFall)
    );

    stim_clkout u_clkout (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .ctrlOn(ctrlOn),
        .stopReq(stopReq),
        .startReq(startReq),
        .clockOut(clockOutPin),
        .stopDone(stopDone)
    );

    assign ctrlOn = (clkCtrl_r != 3'h0);
    assign addrPhase = hsel & htrans[1] & hready;
    assign rdStatus = addrPhase & ~hwrite & hitIdx(haddr, `STIM_IDX_FLAGS);

    // State transitions driven by pin edges, radio events and commands
    always_comb begin
        stateNxt = state_r;
        stopReq = 1'b0;
        startReq = 1'b0;
        unique case (state_r)
            IDLE_CLOCK: begin
                if (pinRise && ctrlOn) begin
                    stateNxt = SLEEP_WAIT;
                    stopReq = 1'b1;
                end else if (pinRise) begin
                    stateNxt = SLEEP;
                end else if (cmdIn.valid) begin
                    stateNxt = cmdIn.target;
                end
            end
            SLEEP_WAIT: begin
                if (pinFall) begin
                    stateNxt = IDLE_CLOCK;
                    startReq = 1'b1;
                end else if (stopDone) begin
                    stateNxt = SLEEP;
                end
            end
            SLEEP: begin
                if (pinFall) begin
                    stateNxt = IDLE_CLOCK;
                    startReq = 1'b1;
                end
            end
            SYNTH_READY: begin
                if (pinRise) begin
                    stateNxt = TX_BUSY;
                end else if (cmdIn.valid) begin
                    stateNxt = cmdIn.target;
                end
            end
            TX_AUTORETRY_READY: begin
                if (pinRise) begin
                    stateNxt = TRANSMITTING_AUTORETRY;
                end else if (cmdIn.valid) begin
                    stateNxt = cmdIn.target;
                end
            end
            TX_BUSY: begin
                if (evtIn.frameDone) begin
                    stateNxt = SYNTH_READY;
                end
            end
            TRANSMITTING_AUTORETRY: begin
                if (evtIn.frameDone) begin
                    stateNxt = TX_AUTORETRY_READY;
                end
            end
            LISTEN: begin
                if (evtIn.sfdDetect) begin
                    stateNxt = RECEIVING;
                end else if (pinRise) begin
                    stateNxt = LISTEN_CLOCKLESS;
                    stopReq = 1'b1;
                end else if (cmdIn.valid) begin
                    stateNxt = cmdIn.target;
                end
            end
            LISTEN_AUTOACK: begin
                if (evtIn.sfdDetect) begin
                    stateNxt = RECEIVING_AUTOACK;
                end else if (pinRise) begin
                    stateNxt = LISTEN_AUTOACK_CLOCKLESS;
                    stopReq = 1'b1;
                end else if (cmdIn.valid) begin
                    stateNxt = cmdIn.target;
                end
            end
            LISTEN_CLOCKLESS: begin
                if (evtIn.sfdDetect) begin
                    stateNxt = RECEIVING;
                    startReq = 1'b1;
                end else if (pinFall) begin
                    stateNxt = LISTEN;
                    startReq = 1'b1;
                end
            end
            LISTEN_AUTOACK_CLOCKLESS: begin
                if (evtIn.sfdDetect) begin
                    stateNxt = RECEIVING_AUTOACK;
                    startReq = 1'b1;
                end else if (pinFall) begin
                    stateNxt = LISTEN_AUTOACK;
                    startReq = 1'b1;
                end
            end
            RECEIVING: begin
                if (evtIn.frameDone) begin
                    stateNxt = LISTEN;
                end
            end
            RECEIVING_AUTOACK: begin
                if (evtIn.frameDone) begin
                    stateNxt = LISTEN_AUTOACK;
                end
            end
            default: begin
                stateNxt = IDLE_CLOCK;
            end
        endcase
    end

    // State register, also shown on the trxState port
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= IDLE_CLOCK;
            trxState <= IDLE_CLOCK;
        end else begin
            state_r <= stateNxt;
            trxState <= stateNxt;
        end
    end

    // Amplifier on only while transmitting
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            paEnable <= 1'b0;
        end else begin
            paEnable <= (stateNxt == TX_BUSY || stateNxt == TRANSMITTING_AUTORETRY) &&
                        !evtIn.lockLost && !(paEnable == 1'b0 && stateNxt == state_r);
        end
    end

    // bit mapping, bits 5 and 4 never set
    // one done bit for tx and rx
    assign evtSet = {evtIn.supplyLow, evtIn.bufferUnderrun, 2'b00, evtIn.frameDone,
                     evtIn.sfdDetect, evtIn.lockLost, evtIn.lockGained};
    assign evtClr = {6'h00, evtIn.lockGained & ~evtIn.lockLost, evtIn.lockLost & ~evtIn.lockGained};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            assign flagsNxt[gi] = evtSet[gi] | (flags_r[gi] & ~rdStatus & ~evtClr[gi]);
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            flags_r <= `STIM_FLAGS_RST;
        end else begin
            flags_r <= flagsNxt;
        end
    end

    // masked OR onto one pin, cleared with the read
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irqPin <= 1'b0;
        end else begin
            // each event gated by its mask bit
            irqPin <= |(flagsNxt & mask_r);
        end
    end

    // Write address captured in the address phase, data used in the next
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPend_r <= 1'b0;
            wrIdx_r <= 8'h00;
        end else begin
            wrPend_r <= addrPhase & hwrite & (haddr[31:10] == 22'h000000);
            wrIdx_r <= haddr[9:2];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mask_r <= `STIM_MASK_RST;
            clkCtrl_r <= `STIM_CLKCTRL_RST;
        end else if (wrPend_r) begin
            if (wrIdx_r == `STIM_IDX_MASK) begin
                mask_r <= hwdata[7:0];
            end
            if (wrIdx_r == `STIM_IDX_CLKCTRL) begin
                clkCtrl_r <= hwdata[2:0];
            end
        end
    end

    // Zero wait states; read data registered at the address phase
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addrPhase && !hwrite) begin
                if (hitIdx(haddr, `STIM_IDX_FLAGS)) begin
                    hrdata <= {24'h000000, flags_r};
                end else if (hitIdx(haddr, `STIM_IDX_MASK)) begin
                    hrdata <= {24'h000000, mask_r};
                end else if (hitIdx(haddr, `STIM_IDX_CLKCTRL)) begin
                    hrdata <= {29'h00000000, clkCtrl_r};
                end else if (hitIdx(haddr, `STIM_IDX_STATE)) begin
                    hrdata <= {28'h0000000, state_r};
                end else begin
                    hrdata <= 32'h00000000;
                end
            end
        end
    end

    // Checks
    a_irq_or: assert property (@(posedge ref_clk) disable iff (!resetn)
        irqPin == |(flags_r & $past(mask_r))) else $error("irq not OR of flags");
    a_read_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        (rdStatus && evtIn == '0) |=> (flags_r == 8'h00 && !irqPin)) else $error("read did not clear");
    a_set_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
        rdStatus |=> (flags_r == $past(evtSet))) else $error("event lost on read");
    a_lock_pair: assert property (@(posedge ref_clk) disable iff (!resetn)
        (evtIn.lockGained && !evtIn.lockLost) |=> (flags_r[`STIM_B_LOCK] && !flags_r[`STIM_B_UNLOCK]))
        else $error("lock pair wrong");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        flags_r[5:4] == 2'b00) else $error("reserved flag set");
    a_tx_start: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == SYNTH_READY && pinRise) |=> state_r == TX_BUSY) else $error("no tx start");
    a_sleep_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == IDLE_CLOCK && pinRise && ctrlOn) |=> (state_r == SLEEP_WAIT) ##36
        (state_r == SLEEP || state_r == IDLE_CLOCK)) else $error("sleep delay wrong");
    a_sleep_now: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == IDLE_CLOCK && pinRise && !ctrlOn) |=> state_r == SLEEP) else $error("no sleep");
    a_wake_rx: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == LISTEN_CLOCKLESS && evtIn.sfdDetect) |=> state_r == RECEIVING)
        else $error("no receive wake");
    a_pa_off: assert property (@(posedge ref_clk) disable iff (!resetn)
        (paEnable && evtIn.lockLost) |=> !paEnable) else $error("amplifier left on");

    c_sleep: cover property (@(posedge ref_clk) disable iff (!resetn) state_r == SLEEP);
    c_tx: cover property (@(posedge ref_clk) disable iff (!resetn) state_r == TRANSMITTING_AUTORETRY);
    c_irq: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(irqPin));
    c_noclk_rx: cover property (@(posedge ref_clk) disable iff (!resetn)
        state_r == LISTEN_AUTOACK_CLOCKLESS ##1 state_r == RECEIVING_AUTOACK);
endmodule : stim_top
